//--- dv/instruction_state_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "state_counter_consts.vh"
module instruction_state_counter_bench;
  logic clk = 0, rst = 1, valid = 0, dp, ps, done, known;
  logic [1:0] sel = 0;
  logic [4:0] form = 0;
  logic [3:0] fc, bc, sc, yc, wc, nc;
  logic [7:0] tot;
  int err_total = 0, n_compared = 0;
  always #4 clk = ~clk;
  periph_model i_periph_model (.sel(sel), .data_periph(dp), .periph_slow(ps));
  instruction_state_counter i_instruction_state_counter (.clk(clk), .rst(rst),
    .valid(valid), .form(form), .data_periph(dp), .periph_slow(ps),
    .done(done), .known(known), .fetch_cnt(fc), .branch_cnt(bc),
    .stack_cnt(sc), .byte_cnt(yc), .word_cnt(wc), .internal_cnt(nc),
    .total_states(tot));
  // Fetch, branch, stack, byte counts packed per form
  function automatic logic [15:0] cnts(input logic [4:0] f);
    case (f)
      `F_ADD_W_IMM, `F_AND_W_IMM,
      `F_AND_L_REG, `F_BRANCH_D8: return 16'h2000;
      `F_ADD_L_IMM, `F_AND_L_IMM: return 16'h3000;
      `F_BAND_IND, `F_BAND_ABS: return 16'h2001;
      `F_BIT_SET_ABS: return 16'h2002;
      `F_CALL_IND: return 16'h2110;
      default: return (f > `F_CALL_IND) ? 16'h0000 : 16'h1000;
    endcase
  endfunction
  // Total states from packed counts; slow module costs three
  function automatic logic [7:0] states(input logic [15:0] c,
                                        input logic [1:0] s);
    return 8'(2 * (c[15:12] + c[11:8] + c[7:4]) + c[3:0] * (&s ? 3 : 2));
  endfunction
  task automatic cmp(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // Back to back: valid stays high between calls
  task automatic step(input logic [4:0] f, input logic [1:0] s);
    logic [15:0] c;
    c = cnts(f);
    form = f;
    sel = s;
    valid = 1;
    @(negedge clk);
    cmp("done", 16'h1, {15'h0, done});
    cmp("known", {15'h0, f <= `F_CALL_IND}, {15'h0, known});
    cmp("counts", c, {fc, bc, sc, yc});
    cmp("word internal", 16'h0, {8'h0, wc, nc});
    cmp("total", {8'h0, states(c, s)}, {8'h0, tot});
  endtask
  // Idle cycle: no done, results hold
  task automatic idle;
    logic [7:0] held;
    held = tot;
    valid = 0;
    @(negedge clk);
    cmp("idle done", 16'h0, {15'h0, done});
    cmp("held total", {8'h0, held}, {8'h0, tot});
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(72));
    repeat (20) @(negedge clk);
    rst = 0;
    step(`F_BIT_SET_ABS, 2'h0);
    step(`F_CALL_IND, 2'h1);
    idle;
    $display("corner done");
    for (int f = 0; f < 32; f++) step(f[4:0], 2'h3);
    for (int f = 0; f < 32; f++) step(f[4:0], 2'h2);
    $display("every form done");
    for (int i = 0; i < 300; i++) begin
      step(5'($urandom % 24), 2'($urandom));
      if (i % 37 == 0) idle;
    end
    $display("random done");
    valid = 0;
    rst = 1;
    @(negedge clk);
    cmp("reset out", 16'h0, {7'h0, done, tot});
    cmp("reset cnt", 16'h0, {fc, bc, sc, yc});
    cmp("reset rest", 16'h0, {7'h0, known, wc, nc});
    rst = 0;
    step(`F_CALL_IND, 2'h0);
    $display("reset done");
    tally_and_finish;
  end
endmodule // instruction_state_counter_bench
`default_nettype wire

//--- dv/isc_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "state_counter_consts.vh"
module isc_props (
  input wire logic clk, rst, valid, data_periph, periph_slow, done, known,
  input wire logic [4:0] form,
  input wire logic [3:0] fetch_cnt, branch_cnt, stack_cnt, byte_cnt,
  input wire logic [3:0] word_cnt, internal_cnt,
  input wire logic [7:0] total_states
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted requests of the forms checked below
  sequence s_call; valid && form == `F_CALL_IND; endsequence
  sequence s_bit_set; valid && form == `F_BIT_SET_ABS; endsequence
  sequence s_branch; valid && form == `F_BRANCH_D8; endsequence
  sequence s_long_reg; valid && form == `F_AND_L_REG; endsequence
  sequence s_unknown; valid && form > `F_CALL_IND; endsequence
  sequence s_long_imm;
    valid && (form == `F_ADD_L_IMM || form == `F_AND_L_IMM);
  endsequence
  sequence s_word_imm;
    valid && (form == `F_ADD_W_IMM || form == `F_AND_W_IMM);
  endsequence
  a_done_follows: assert property (valid |=> done)
    else $error("done late");
  a_no_stray: assert property (
    !valid |=> !done && $stable(total_states)) else $error("stray done");
  a_weighted_sum: assert property (done |-> total_states ==
    2 * (fetch_cnt + branch_cnt + stack_cnt) + internal_cnt +
    (byte_cnt + word_cnt) * ($past(data_periph && periph_slow) ? 3 : 2))
    else $error("bad sum");
  a_bit_set_cnt: assert property (s_bit_set |=>
    fetch_cnt == 2 && byte_cnt == 2) else $error("bit set");
  a_call_cnt: assert property (s_call |=>
    fetch_cnt == 2 && branch_cnt == 1 && stack_cnt == 1 && total_states == 8)
    else $error("call");
  a_branch_cnt: assert property (s_branch |=>
    fetch_cnt == 2 && internal_cnt == 0) else $error("branch");
  a_long_imm: assert property (s_long_imm |=> fetch_cnt == 3)
    else $error("long imm");
  a_word_imm: assert property (s_word_imm |=> fetch_cnt == 2)
    else $error("word imm");
  a_and_long: assert property (s_long_reg |=> fetch_cnt == 2)
    else $error("long reg and");
  a_unknown_zero: assert property (s_unknown |=>
    !known && total_states == 0) else $error("unknown form");
endmodule // isc_props
bind instruction_state_counter isc_props i_p (.*);
`default_nettype wire

//--- dv/periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far side: 0,1 memory, 2 fast module, 3 slow module
module periph_model (
  input wire logic [1:0] sel,
  output logic data_periph,
  output logic periph_slow
);
  assign data_periph = sel[1];
  assign periph_slow = &sel;
endmodule // periph_model
`default_nettype wire

//--- rtl/instruction_state_counter.v
// Overview of operation
// - Total states equals weighted sum of categories
// - Six cycle categories, fixed counts per form
// - Fetch from on-chip memory takes two states
// - Peripheral data access takes two or three
// - Internal operation cycle takes one state
// - Bit set absolute: two fetch, two byte
// - Indirect call: two fetch, branch, stack
// - Long immediate add/and: three fetches only
// - Word immediate add/and: two fetches only
// - Short add/and forms: single fetch only
// - Bit-and memory two fetch one byte
// - Short branches: two fetches, no internal
`include "state_counter_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module instruction_state_counter (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Decoded instruction in
  input wire valid,
  input wire [`FORM_W-1:0] form,
  input wire data_periph, // Data goes to a peripheral module
  input wire periph_slow, // That peripheral needs three states
  // Results out
  output reg done,
  output reg known, // Form was recognised
  output reg [3:0] fetch_cnt,
  output reg [3:0] branch_cnt,
  output reg [3:0] stack_cnt,
  output reg [3:0] byte_cnt,
  output reg [3:0] word_cnt,
  output reg [3:0] internal_cnt,
  output reg [`TOTAL_W-1:0] total_states
);

////////////////////////////////////////////////////////////////////////////
// Cycle counts per form; no operand or branch outcome enters
reg [3:0] ci, cj, ck, cl, cm, cn; // Category counts
reg hit; // Decoded a covered form
always @* begin
  ci = `CNT_0;
  cj = `CNT_0;
  ck = `CNT_0;
  cl = `CNT_0;
  cm = `CNT_0;
  cn = `CNT_0;
  hit = 1'b1;
  case (form)
    // Byte add, short immediate
    `F_ADD_B_IMM: begin
      ci = `CNT_1;
    end
    // Byte add, register to register
    `F_ADD_B_REG: begin
      ci = `CNT_1;
    end
    // Word add, immediate needs a second fetch
    `F_ADD_W_IMM: begin
      ci = `CNT_2;
    end
    // Word add, register to register
    `F_ADD_W_REG: begin
      ci = `CNT_1;
    end
    // Long add, immediate needs two extra fetches
    `F_ADD_L_IMM: begin
      ci = `CNT_3;
    end
    // Long add, register to register
    `F_ADD_L_REG: begin
      ci = `CNT_1;
    end
    // Add a small constant to a long register
    `F_ADD_SMALL: begin
      ci = `CNT_1;
    end
    // Add with carry, immediate
    `F_ADD_CARRY_IMM: begin
      ci = `CNT_1;
    end
    // Add with carry, register
    `F_ADD_CARRY_REG: begin
      ci = `CNT_1;
    end
    // Byte and, short immediate
    `F_AND_B_IMM: begin
      ci = `CNT_1;
    end
    // Byte and, register to register
    `F_AND_B_REG: begin
      ci = `CNT_1;
    end
    // Word and, immediate needs a second fetch
    `F_AND_W_IMM: begin
      ci = `CNT_2;
    end
    // Word and, register to register
    `F_AND_W_REG: begin
      ci = `CNT_1;
    end
    // Long and, immediate needs two extra fetches
    `F_AND_L_IMM: begin
      ci = `CNT_3;
    end
    // Long and, register form is a two-word opcode
    `F_AND_L_REG: begin
      ci = `CNT_2;
    end
    // And into the condition code register
    `F_AND_COND: begin
      ci = `CNT_1;
    end
    // Bit-and to carry, register operand
    `F_BAND_REG: begin
      ci = `CNT_1;
    end
    // Bit-and to carry, register-indirect memory operand
    `F_BAND_IND: begin
      ci = `CNT_2;
      cl = `CNT_1; // One byte read
    end
    // Bit-and to carry, short absolute memory operand
    `F_BAND_ABS: begin
      ci = `CNT_2;
      cl = `CNT_1; // One byte read
    end
    // Short branch; taken or not, same cost
    `F_BRANCH_D8: begin
      ci = `CNT_2;
    end
    // Bit set, read-modify-write of one byte
    `F_BIT_SET_ABS: begin
      ci = `CNT_2;
      cl = `CNT_2; // Byte read and byte write
    end
    // Memory-indirect call: vector read and one push
    `F_CALL_IND: begin
      ci = `CNT_2;
      cj = `CNT_1; // Branch address read
      ck = `CNT_1; // Stack push
    end
    // Uncovered form reports zero, never a guess
    default: begin
      hit = 1'b0;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////
// Per-cycle state weights
// Memory and fast modules cost two; slow modules cost three
wire [3:0] s_data; // Data access weight for this target
assign s_data = (data_periph && periph_slow) ? `S_PERIPH_SLOW
                                             : `S_DATA_MEM;

////////////////////////////////////////////////////////////////////////////
// Widen counts first, so no product is cut short
wire [`TOTAL_W-1:0] ci_w; // Fetch cycles
wire [`TOTAL_W-1:0] cj_w; // Branch address reads
wire [`TOTAL_W-1:0] ck_w; // Stack cycles
wire [`TOTAL_W-1:0] cl_w; // Byte data cycles
wire [`TOTAL_W-1:0] cm_w; // Word data cycles
wire [`TOTAL_W-1:0] cn_w; // Internal cycles
assign ci_w = {{(`TOTAL_W-`CNT_W){1'b0}}, ci};
assign cj_w = {{(`TOTAL_W-`CNT_W){1'b0}}, cj};
assign ck_w = {{(`TOTAL_W-`CNT_W){1'b0}}, ck};
assign cl_w = {{(`TOTAL_W-`CNT_W){1'b0}}, cl};
assign cm_w = {{(`TOTAL_W-`CNT_W){1'b0}}, cm};
assign cn_w = {{(`TOTAL_W-`CNT_W){1'b0}}, cn};

// Weights widened the same way
wire [`TOTAL_W-1:0] w_fetch; // States per fetch
wire [`TOTAL_W-1:0] w_branch; // States per branch address read
wire [`TOTAL_W-1:0] w_stack; // States per stack cycle
wire [`TOTAL_W-1:0] w_data; // States per data cycle
wire [`TOTAL_W-1:0] w_internal; // States per internal cycle
assign w_fetch = {{(`TOTAL_W-`CNT_W){1'b0}}, `S_FETCH_MEM};
assign w_branch = {{(`TOTAL_W-`CNT_W){1'b0}}, `S_BRANCH_MEM};
assign w_stack = {{(`TOTAL_W-`CNT_W){1'b0}}, `S_STACK_MEM};
assign w_data = {{(`TOTAL_W-`CNT_W){1'b0}}, s_data};
assign w_internal = {{(`TOTAL_W-`CNT_W){1'b0}}, `S_INTERNAL};

////////////////////////////////////////////////////////////////////////////
// Weighted sum; the costliest covered form stays far below 8 bits
// Byte and word data share one weight: a form has one data target
wire [`TOTAL_W-1:0] next_total;
assign next_total = ci_w * w_fetch
                  + cj_w * w_branch
                  + ck_w * w_stack
                  + cl_w * w_data
                  + cm_w * w_data
                  + cn_w * w_internal;

////////////////////////////////////////////////////////////////////////////
// Registered outputs, one cycle after valid
always @(posedge clk) begin
  if (rst) begin
    done <= 1'b0;
    known <= 1'b0;
    fetch_cnt <= `CNT_0;
    branch_cnt <= `CNT_0;
    stack_cnt <= `CNT_0;
    byte_cnt <= `CNT_0;
    word_cnt <= `CNT_0;
    internal_cnt <= `CNT_0;
    total_states <= {`TOTAL_W{1'b0}};
  end else begin
    done <= valid;
    if (valid) begin // Hold last result otherwise
      known <= hit;
      fetch_cnt <= ci;
      branch_cnt <= cj;
      stack_cnt <= ck;
      byte_cnt <= cl;
      word_cnt <= cm;
      internal_cnt <= cn;
      total_states <= next_total;
    end
  end
end
endmodule // instruction_state_counter
`default_nettype wire

//--- rtl/state_counter_consts.vh
`ifndef STATE_COUNTER_CONSTS_VH
`define STATE_COUNTER_CONSTS_VH
// Instruction form codes on the form input
`define FORM_W 5
`define F_ADD_B_IMM 5'h00
`define F_ADD_B_REG 5'h01
`define F_ADD_W_IMM 5'h02
`define F_ADD_W_REG 5'h03
`define F_ADD_L_IMM 5'h04
`define F_ADD_L_REG 5'h05
`define F_ADD_SMALL 5'h06
`define F_ADD_CARRY_IMM 5'h07
`define F_ADD_CARRY_REG 5'h08
`define F_AND_B_IMM 5'h09
`define F_AND_B_REG 5'h0a
`define F_AND_W_IMM 5'h0b
`define F_AND_W_REG 5'h0c
`define F_AND_L_IMM 5'h0d
`define F_AND_L_REG 5'h0e
`define F_AND_COND 5'h0f
`define F_BAND_REG 5'h10
`define F_BAND_IND 5'h11
`define F_BAND_ABS 5'h12
`define F_BRANCH_D8 5'h13
`define F_BIT_SET_ABS 5'h14
`define F_CALL_IND 5'h15
// Per-cycle state counts
`define S_FETCH_MEM 4'h2
`define S_BRANCH_MEM 4'h2
`define S_STACK_MEM 4'h2
`define S_DATA_MEM 4'h2
`define S_PERIPH_SLOW 4'h3
`define S_INTERNAL 4'h1
// Per-form cycle counts
`define CNT_0 4'h0
`define CNT_1 4'h1
`define CNT_2 4'h2
`define CNT_3 4'h3
`define CNT_W 4
`define TOTAL_W 8
`endif
